// ===== rtl/nrd_defines.svh
// Register offsets, field positions, reset values and timing counts of the node reset/diagnostics block
`ifndef NRD_DEFINES_SVH
`define NRD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (APB, one aligned word each)
// ----------------------------------------------------------------------------
`define NRD_OFS_CONFIG 12'h000
`define NRD_OFS_SETUP_ONE 12'h004
`define NRD_OFS_STATION_ID 12'h008
`define NRD_OFS_TENTATIVE_ID 12'h00C
`define NRD_OFS_DIAG_STATUS 12'h010
`define NRD_OFS_STATUS 12'h014
`define NRD_OFS_COMMAND 12'h018
`define NRD_OFS_ADDR_PTR 12'h01C
`define NRD_OFS_NEXT_ID 12'h020
`define NRD_OFS_RAM_WATCH 12'h024
`define NRD_OFS_HOST_MODE 12'h028

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define NRD_CFG_SOFT_RESET 7
`define NRD_CFG_TX_ENABLE 5
`define NRD_CFG_TSEL_B 4
`define NRD_CFG_TSEL_A 3
`define NRD_SU1_NAK_LIMIT_SEL 0
`define NRD_DS_SELF_RECONFIG 7
`define NRD_DS_DUPLICATE_ID 6
`define NRD_DS_RECEIVE_ACT 5
`define NRD_DS_TOKEN_SEEN 4
`define NRD_DS_EXCESSIVE_NAK 3
`define NRD_DS_TENTATIVE_MATCH 2
`define NRD_DS_NEW_NEXT_ID 1
`define NRD_ST_TX_AVAILABLE 0
`define NRD_ST_CORE_AWAKE 1
`define NRD_ST_JOINED 2
`define NRD_ST_IN_RESET 3

// ----------------------------------------------------------------------------
// Command codes, reset values, fixed data
// ----------------------------------------------------------------------------
`define NRD_CMD_DISABLE_TX 8'h01
`define NRD_CMD_CLEAR_FLAGS 8'h1E
`define NRD_CFG_RESET 8'h18
`define NRD_RAM_PATTERN 8'hD1
`define NRD_RAM_ADDR0 11'h000
`define NRD_RAM_ADDR1 11'h001

// ----------------------------------------------------------------------------
// Timing: glitch filter 5 crystal periods, duplicate-ID windows 420/840 ms
// ----------------------------------------------------------------------------
`define NRD_CLK_NS 10
`define NRD_FILTER_PERIODS 5
`define NRD_DUP_SHORT_MS 420
`define NRD_DUP_LONG_MS 840
`define NRD_DUP_SHORT_CYC ((`NRD_DUP_SHORT_MS * 64'd1000000) / `NRD_CLK_NS)
`define NRD_DUP_LONG_CYC ((`NRD_DUP_LONG_MS * 64'd1000000) / `NRD_CLK_NS)
`define NRD_NAK_LONG 8'd128
`define NRD_NAK_SHORT 8'd4

`endif

// ===== rtl/nrd_pkg.sv
// Types shared by the node reset/diagnostics block
package nrd_pkg;
    typedef enum logic [2:0] {
        NRD_WAKE_IDLE = 3'b001,
        NRD_WAKE_WR0 = 3'b010,
        NRD_WAKE_WR1 = 3'b100
    } nrd_wake_e;
    typedef enum logic [1:0] {
        NRD_BUS_UNKNOWN = 2'b01,
        NRD_BUS_FOUND = 2'b10
    } nrd_bus_e;
endpackage : nrd_pkg

// ===== rtl/nrd_node_reset_diag.sv
// Reset, wake-up and network diagnostic logic of a token-passing node controller
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "nrd_defines.svh"

module nrd_node_reset_diag
    import nrd_pkg::*;
#(
    parameter int FILTER_CYC = `NRD_FILTER_PERIODS,
    parameter longint DUP_SHORT_CYC = `NRD_DUP_SHORT_CYC,
    parameter longint DUP_LONG_CYC = `NRD_DUP_LONG_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RESET_INPUT_LOW,
    input wire logic LINE_RECEIVE_INPUT,
    input wire logic TOKEN_OBSERVED,
    input wire logic TOKEN_FROM_SELF,
    input wire logic [7:0] TOKEN_DEST_ID,
    input wire logic TOKEN_RESPONSE,
    input wire logic TOKEN_TO_SELF,
    input wire logic NETWORK_RECONFIG_FLAG_TIMER_EXPIRED,
    input wire logic NAK_RECEIVED,
    input wire logic [7:0] NEXT_NODE_ID,
    output logic RAM_WR,
    output logic [10:0] RAM_ADDR,
    output logic [7:0] RAM_WDATA,
    output logic CORE_AWAKE,
    output logic JOIN_ENABLE,
    output logic TRANSMIT_ENABLE,
    output logic START_RECONFIG,
    output logic NODE_IN_RESET
);

    // ------------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------------
    logic rst_meta, rst_n;
    logic [1:0] pin_rst_s, pin_rx_s;
    logic [7:0] filt_cnt;
    logic hw_reset;
    logic soft_reset;

    // Release of the asynchronous reset through two flops
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin inputs pass two flops before anything reads them
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_rst_s <= 2'b11;
            pin_rx_s <= 2'b00;
        end else begin
            pin_rst_s <= {pin_rst_s[0], RESET_INPUT_LOW};
            pin_rx_s <= {pin_rx_s[0], LINE_RECEIVE_INPUT};
        end
    end

    // Glitch filter: reset pin must stay low for FILTER_CYC clocks in a row
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            filt_cnt <= 8'h00;
            hw_reset <= 1'b0;
        end else if (pin_rst_s[1]) begin
            filt_cnt <= 8'h00;
            hw_reset <= 1'b0;
        end else if (filt_cnt >= 8'(FILTER_CYC - 1)) begin
            hw_reset <= 1'b1;
        end else begin
            filt_cnt <= filt_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] config_reg, setup_one_register, station_id, tentative_id, addr_ptr;
    logic [7:0] next_id_seen;
    logic self_reconfig_flag, duplicate_id_flag, receive_activity_flag, token_seen_flag;
    logic excessive_nak_flag, tentative_match_flag, new_next_id_flag, transmitter_available;
    logic tx_disable_pending;
    logic [7:0] nak_cnt;
    logic [63:0] dup_cnt;
    logic dup_armed;
    nrd_wake_e wake_state;
    nrd_bus_e bus_state;
    logic odd_write_seen, host_mode;
    logic [7:0] last_ram_data;

    logic acc, wr, rd;
    logic node_reset;
    logic transmit_enable_bit, awake;
    logic [7:0] nak_limit;
    logic [63:0] dup_limit;

    assign acc = PSEL && PENABLE;
    assign wr = acc && PWRITE;
    assign rd = acc && !PWRITE;
    assign soft_reset = config_reg[`NRD_CFG_SOFT_RESET];
    assign node_reset = soft_reset || hw_reset;
    assign transmit_enable_bit = config_reg[`NRD_CFG_TX_ENABLE];
    assign awake = (station_id != 8'h00) && !node_reset;
    assign nak_limit = setup_one_register[`NRD_SU1_NAK_LIMIT_SEL] ? `NRD_NAK_SHORT : `NRD_NAK_LONG;
    // Longer window unless both timeout selects are one
    assign dup_limit = (config_reg[`NRD_CFG_TSEL_A] && config_reg[`NRD_CFG_TSEL_B]) ?
        64'(DUP_SHORT_CYC) : 64'(DUP_LONG_CYC);

    // Address decode shared by the write and read paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Registers that survive a software reset; only NRST or the filtered pin clears them
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= `NRD_CFG_RESET;
            setup_one_register <= 8'h00;
            addr_ptr <= 8'h00;
        end else if (hw_reset) begin
            config_reg <= `NRD_CFG_RESET;
            setup_one_register <= 8'h00;
            addr_ptr <= 8'h00;
        end else if (wr) begin
            // Soft reset does not touch these; software clears bit 7 itself
            if (hit(PADDR, `NRD_OFS_CONFIG)) config_reg <= PWDATA[7:0];
            if (hit(PADDR, `NRD_OFS_SETUP_ONE)) setup_one_register <= PWDATA[7:0];
            if (hit(PADDR, `NRD_OFS_ADDR_PTR)) addr_ptr <= PWDATA[7:0];
        end
    end

    // Host bus type: odd-address write followed by odd-address read; hardware reset only
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= NRD_BUS_UNKNOWN;
            odd_write_seen <= 1'b0;
            host_mode <= 1'b0;
        end else if (hw_reset) begin
            bus_state <= NRD_BUS_UNKNOWN;
            odd_write_seen <= 1'b0;
            host_mode <= 1'b0;
        end else begin
            unique case (bus_state)
                NRD_BUS_UNKNOWN: begin
                    if (wr && PADDR[2]) odd_write_seen <= 1'b1;
                    if (rd && PADDR[2] && odd_write_seen) begin
                        bus_state <= NRD_BUS_FOUND;
                        host_mode <= PADDR[3];
                    end
                end
                NRD_BUS_FOUND: begin
                    bus_state <= NRD_BUS_FOUND;
                end
            endcase
        end
    end

    // Station and tentative ID; cleared by any reset, station write launches the RAM sequence
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            station_id <= 8'h00;
            tentative_id <= 8'h00;
        end else if (node_reset) begin
            station_id <= 8'h00;
            tentative_id <= 8'h00;
        end else if (wr) begin
            if (hit(PADDR, `NRD_OFS_STATION_ID)) station_id <= PWDATA[7:0];
            if (hit(PADDR, `NRD_OFS_TENTATIVE_ID)) tentative_id <= PWDATA[7:0];
        end
    end

    // Two buffer writes after every station ID write that arrives in NRD_WAKE_IDLE outside node reset
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wake_state <= NRD_WAKE_IDLE;
            RAM_WR <= 1'b0;
            RAM_ADDR <= `NRD_RAM_ADDR0;
            RAM_WDATA <= 8'h00;
            last_ram_data <= 8'h00;
        end else if (node_reset) begin
            wake_state <= NRD_WAKE_IDLE;
            RAM_WR <= 1'b0;
        end else begin
            unique case (wake_state)
                NRD_WAKE_IDLE: begin
                    RAM_WR <= 1'b0;
                    if (wr && hit(PADDR, `NRD_OFS_STATION_ID)) wake_state <= NRD_WAKE_WR0;
                end
                NRD_WAKE_WR0: begin
                    RAM_WR <= 1'b1;
                    RAM_ADDR <= `NRD_RAM_ADDR0;
                    RAM_WDATA <= `NRD_RAM_PATTERN;
                    last_ram_data <= `NRD_RAM_PATTERN;
                    wake_state <= NRD_WAKE_WR1;
                end
                NRD_WAKE_WR1: begin
                    RAM_WR <= 1'b1;
                    RAM_ADDR <= `NRD_RAM_ADDR1;
                    RAM_WDATA <= station_id;
                    last_ram_data <= station_id;
                    wake_state <= NRD_WAKE_IDLE;
                end
            endcase
        end
    end

    // Core outputs; all registered, transmitter off in any reset
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CORE_AWAKE <= 1'b0;
            JOIN_ENABLE <= 1'b0;
            TRANSMIT_ENABLE <= 1'b0;
            START_RECONFIG <= 1'b0;
            NODE_IN_RESET <= 1'b1;
        end else begin
            CORE_AWAKE <= awake;
            JOIN_ENABLE <= awake && transmit_enable_bit;
            TRANSMIT_ENABLE <= awake && transmit_enable_bit && !tx_disable_pending;
            START_RECONFIG <= awake && transmit_enable_bit && NETWORK_RECONFIG_FLAG_TIMER_EXPIRED;
            NODE_IN_RESET <= node_reset;
        end
    end

    // Duplicate-ID timer: restarts on each station ID write, flag within the window
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dup_cnt <= 64'h0;
            dup_armed <= 1'b0;
        end else if (node_reset || (wr && hit(PADDR, `NRD_OFS_STATION_ID))) begin
            dup_cnt <= 64'h0;
            dup_armed <= !node_reset;
        end else if (dup_armed) begin
            if (dup_cnt >= dup_limit - 64'h1) dup_armed <= 1'b0;
            else dup_cnt <= dup_cnt + 64'h1;
        end
    end

    // Flags clear at the edge that latches read data, so no event slips between; set wins
    logic ds_read, clr_cmd, dis_cmd, nak_hit;
    assign ds_read = PSEL && !PENABLE && !PWRITE && hit(PADDR, `NRD_OFS_DIAG_STATUS);
    assign clr_cmd = wr && hit(PADDR, `NRD_OFS_COMMAND) && PWDATA[7:0] == `NRD_CMD_CLEAR_FLAGS;
    assign dis_cmd = wr && hit(PADDR, `NRD_OFS_COMMAND) && PWDATA[7:0] == `NRD_CMD_DISABLE_TX;
    assign nak_hit = awake && NAK_RECEIVED && (nak_cnt + 8'h01 >= nak_limit);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            self_reconfig_flag <= 1'b0;
            duplicate_id_flag <= 1'b0;
            receive_activity_flag <= 1'b0;
            token_seen_flag <= 1'b0;
            tentative_match_flag <= 1'b0;
            new_next_id_flag <= 1'b0;
        end else if (node_reset) begin
            self_reconfig_flag <= 1'b0;
            duplicate_id_flag <= 1'b0;
            receive_activity_flag <= 1'b0;
            token_seen_flag <= 1'b0;
            tentative_match_flag <= 1'b0;
            new_next_id_flag <= 1'b0;
        end else begin
            if (awake && transmit_enable_bit && NETWORK_RECONFIG_FLAG_TIMER_EXPIRED) self_reconfig_flag <= 1'b1;
            else if (ds_read) self_reconfig_flag <= 1'b0;
            if (awake && dup_armed && TOKEN_RESPONSE && TOKEN_DEST_ID == station_id)
                duplicate_id_flag <= 1'b1;
            else if (ds_read) duplicate_id_flag <= 1'b0;
            if (pin_rx_s[1]) receive_activity_flag <= 1'b1;
            else if (ds_read) receive_activity_flag <= 1'b0;
            if (TOKEN_OBSERVED && !TOKEN_FROM_SELF) token_seen_flag <= 1'b1;
            else if (ds_read) token_seen_flag <= 1'b0;
            if (awake && tentative_id != 8'h00 && TOKEN_RESPONSE && TOKEN_DEST_ID == tentative_id)
                tentative_match_flag <= 1'b1;
            else if (ds_read) tentative_match_flag <= 1'b0;
            if (awake && NEXT_NODE_ID != next_id_seen) new_next_id_flag <= 1'b1;
            else if (ds_read) new_next_id_flag <= 1'b0;
        end
    end

    // Next-node tracking runs while asleep too, so waking up raises no false change
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) next_id_seen <= 8'h00;
        else if (node_reset) next_id_seen <= 8'h00;
        else next_id_seen <= NEXT_NODE_ID;
    end

    // Wrapping NAK counter; clear-flags drops the flag, a new run sets it again
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            nak_cnt <= 8'h00;
            excessive_nak_flag <= 1'b0;
        end else if (node_reset) begin
            nak_cnt <= 8'h00;
            excessive_nak_flag <= 1'b0;
        end else begin
            if (nak_hit) nak_cnt <= 8'h00;
            else if (awake && NAK_RECEIVED) nak_cnt <= nak_cnt + 8'h01;
            if (nak_hit) excessive_nak_flag <= 1'b1;
            else if (clr_cmd) excessive_nak_flag <= 1'b0;
        end
    end

    // Disable transmitter: transmitter available returns on the next token to this node
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_disable_pending <= 1'b0;
            transmitter_available <= 1'b1;
        end else if (node_reset) begin
            tx_disable_pending <= 1'b0;
            transmitter_available <= 1'b1;
        end else if (dis_cmd) begin
            tx_disable_pending <= 1'b1;
            transmitter_available <= 1'b0;
        end else if (tx_disable_pending && TOKEN_TO_SELF) begin
            tx_disable_pending <= 1'b0;
            transmitter_available <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // APB read path: zero-wait, unmapped reads zero with error
    // ------------------------------------------------------------------------
    logic [31:0] rdata_mux;
    logic map_hit;
    always_comb begin
        rdata_mux = 32'h0;
        map_hit = 1'b1;
        unique case (PADDR)
            `NRD_OFS_CONFIG: rdata_mux = {24'h0, config_reg};
            `NRD_OFS_SETUP_ONE: rdata_mux = {24'h0, setup_one_register};
            `NRD_OFS_STATION_ID: rdata_mux = {24'h0, station_id};
            `NRD_OFS_TENTATIVE_ID: rdata_mux = {24'h0, tentative_id};
            `NRD_OFS_DIAG_STATUS: rdata_mux = {24'h0, self_reconfig_flag, duplicate_id_flag,
                receive_activity_flag, token_seen_flag, excessive_nak_flag, tentative_match_flag,
                new_next_id_flag, 1'b0};
            `NRD_OFS_STATUS: rdata_mux = {28'h0, node_reset, JOIN_ENABLE, CORE_AWAKE, transmitter_available};
            `NRD_OFS_COMMAND: rdata_mux = 32'h0;
            `NRD_OFS_ADDR_PTR: rdata_mux = {24'h0, addr_ptr};
            `NRD_OFS_NEXT_ID: rdata_mux = {24'h0, next_id_seen};
            `NRD_OFS_RAM_WATCH: rdata_mux = {24'h0, last_ram_data};
            `NRD_OFS_HOST_MODE: rdata_mux = {30'h0, bus_state == NRD_BUS_FOUND, host_mode};
            default: map_hit = 1'b0;
        endcase
    end

    // Registered answer: PREADY one cycle after setup, i.e. in the access cycle
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !map_hit;
            PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rdata_mux : 32'h0;
        end
    end

endmodule : nrd_node_reset_diag

// ===== bench/nrd_chk.sv
// Port-level assertions for the node reset/diagnostics block
`timescale 1ns/1ps
`include "nrd_defines.svh"
module nrd_chk (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic RESET_INPUT_LOW,
    input wire logic NETWORK_RECONFIG_FLAG_TIMER_EXPIRED,
    input wire logic RAM_WR,
    input wire logic [10:0] RAM_ADDR,
    input wire logic [7:0] RAM_WDATA,
    input wire logic CORE_AWAKE,
    input wire logic JOIN_ENABLE,
    input wire logic TRANSMIT_ENABLE,
    input wire logic START_RECONFIG,
    input wire logic NODE_IN_RESET
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Reset filter, wake-up writes, sleep and join gating; reset windows are long enough for sync delays
    AST_RAM_START: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == `NRD_OFS_STATION_ID
        && !NODE_IN_RESET |-> ##[1:3] (RAM_WR && RAM_ADDR == `NRD_RAM_ADDR0)) else $error("no RAM write");
    AST_RAM_ORDER: assert property (RAM_WR && RAM_ADDR == `NRD_RAM_ADDR0 |-> RAM_WDATA == `NRD_RAM_PATTERN
        ##1 (RAM_WR && RAM_ADDR == `NRD_RAM_ADDR1)) else $error("RAM write order wrong");
    AST_RESET_QUIET: assert property (NODE_IN_RESET [*3] |-> !TRANSMIT_ENABLE && !JOIN_ENABLE && !CORE_AWAKE)
        else $error("active while in reset");
    AST_JOIN_AWAKE: assert property ($rose(JOIN_ENABLE) |-> CORE_AWAKE && $past(CORE_AWAKE))
        else $error("joined while asleep");
    AST_NETWORK_RECONFIG_FLAG_CAUSE: assert property (START_RECONFIG |-> $past(NETWORK_RECONFIG_FLAG_TIMER_EXPIRED) && $past(CORE_AWAKE))
        else $error("reconfiguration without cause");
    AST_NETWORK_RECONFIG_FLAG_FOLLOW: assert property (NETWORK_RECONFIG_FLAG_TIMER_EXPIRED && CORE_AWAKE && TRANSMIT_ENABLE
        |=> START_RECONFIG) else $error("reconfiguration missing");
    AST_GLITCH_IGNORED: assert property ($rose(RESET_INPUT_LOW) && $past(RESET_INPUT_LOW, 5) && !NODE_IN_RESET
        |=> !NODE_IN_RESET [*6]) else $error("short pin pulse caused reset");
    AST_LONG_PULSE: assert property (!RESET_INPUT_LOW [*8] |-> ##[0:3] NODE_IN_RESET)
        else $error("long pin pulse ignored");
endmodule : nrd_chk
bind nrd_node_reset_diag nrd_chk i_chk (.*);

// ===== bench/nrd_line_model.sv
// Line-side partner: receive level, token, NAK and timer events seen by the node
`timescale 1ns/1ps
module nrd_line_model (
    input wire logic CLK,
    output logic LINE_RECEIVE_INPUT,
    output logic TOKEN_OBSERVED,
    output logic TOKEN_FROM_SELF,
    output logic [7:0] TOKEN_DEST_ID,
    output logic TOKEN_RESPONSE,
    output logic TOKEN_TO_SELF,
    output logic NETWORK_RECONFIG_FLAG_TIMER_EXPIRED,
    output logic NAK_RECEIVED,
    output logic [7:0] NEXT_NODE_ID
);
    // Quiet line at start
    initial begin
        {LINE_RECEIVE_INPUT, TOKEN_OBSERVED, TOKEN_FROM_SELF, TOKEN_RESPONSE, TOKEN_TO_SELF} = 5'h00;
        {NETWORK_RECONFIG_FLAG_TIMER_EXPIRED, NAK_RECEIVED} = 2'b00;
        TOKEN_DEST_ID = 8'hA5;
        NEXT_NODE_ID = 8'h01;
    end
    // One token; the ID is inverted afterwards so a stale value is never trusted
    task automatic token(input logic [7:0] id, input logic own, input logic mine, input logic resp);
        {TOKEN_OBSERVED, TOKEN_FROM_SELF, TOKEN_TO_SELF, TOKEN_RESPONSE, TOKEN_DEST_ID} <= {1'b1, own, mine, resp, id};
        @(posedge CLK);
        {TOKEN_OBSERVED, TOKEN_FROM_SELF, TOKEN_TO_SELF, TOKEN_RESPONSE, TOKEN_DEST_ID} <= {4'h0, ~id};
        @(posedge CLK);
    endtask : token
    // One-cycle NAK, timer expiry or line activity
    task automatic ev(input logic nak, input logic tmr, input logic act);
        {NAK_RECEIVED, NETWORK_RECONFIG_FLAG_TIMER_EXPIRED, LINE_RECEIVE_INPUT} <= {nak, tmr, act};
        @(posedge CLK);
        {NAK_RECEIVED, NETWORK_RECONFIG_FLAG_TIMER_EXPIRED, LINE_RECEIVE_INPUT} <= 3'b000;
        @(posedge CLK);
    endtask : ev
    // New next-node identity, held as a level from here on
    task automatic next_node(input logic [7:0] id);
        NEXT_NODE_ID <= id;
        @(posedge CLK);
    endtask : next_node
endmodule : nrd_line_model

// ===== bench/tb.sv
// Self-checking bench for the node reset/diagnostics block
`timescale 1ns/1ps
module tb;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic RESET_INPUT_LOW = 1'b1;
    logic [31:0] PRDATA, rd;
    logic PREADY, PSLVERR, LINE_RECEIVE_INPUT, TOKEN_OBSERVED, TOKEN_FROM_SELF, TOKEN_RESPONSE, TOKEN_TO_SELF, err;
    logic NETWORK_RECONFIG_FLAG_TIMER_EXPIRED, NAK_RECEIVED, RAM_WR, CORE_AWAKE, JOIN_ENABLE, TRANSMIT_ENABLE, START_RECONFIG;
    logic NODE_IN_RESET;
    logic [7:0] TOKEN_DEST_ID, NEXT_NODE_ID, RAM_WDATA;
    logic [10:0] RAM_ADDR;
    logic [18:0] ram_q[$];
    int failures = 0;
    int checks = 0;
    always #5 CLK = ~CLK;
    // Short duplicate-ID windows keep the run brief
    nrd_node_reset_diag #(.DUP_SHORT_CYC(50), .DUP_LONG_CYC(100)) i_dut (.*);
    nrd_line_model i_line (.*);
    // Log every RAM write
    always @(posedge CLK) begin
        if (RAM_WR === 1'b1) begin
            ram_q.push_back({RAM_ADDR, RAM_WDATA});
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // APB transfer; waits for PREADY under a bound, one idle cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, 24'h0, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            close_out();
        end
        rd = PRDATA;
        err = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
        @(posedge CLK);
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd & m, e);
    endtask : rdchk
    task automatic t_wake();
        rdchk(12'h000, 32'hFF, 32'h18);
        apb(1'b0, 12'h3FC, 8'h00);
        chk(32'({err, rd[7:0]}), 32'h100);
        apb(1'b1, 12'h008, 8'h00);
        repeat (4) @(posedge CLK);
        chk(32'({CORE_AWAKE, JOIN_ENABLE}), 32'h0);
        apb(1'b1, 12'h004, 8'h01);
        apb(1'b0, 12'h004, 8'h00);
        rdchk(12'h028, 32'h2, 32'h2);
        // One timeout select cleared: only the long window still catches a late response
        apb(1'b1, 12'h000, 8'h10);
        ram_q.delete();
        apb(1'b1, 12'h008, 8'h2A);
        repeat (3) @(posedge CLK);
        chk(32'(ram_q.size()), 32'h2);
        chk(32'(ram_q[0]), 32'h000D1);
        chk(32'(ram_q[1]), 32'h0012A);
        chk(32'({CORE_AWAKE, JOIN_ENABLE}), 32'h2);
        repeat (60) @(posedge CLK);
        i_line.token(8'h2A, 1'b0, 1'b0, 1'b1);
        rdchk(12'h010, 32'h42, 32'h40);
        rdchk(12'h010, 32'h40, 32'h0);
        $display("done wake");
    endtask : t_wake
    task automatic t_diag();
        i_line.ev(1'b0, 1'b0, 1'b1);
        i_line.token(8'h05, 1'b1, 1'b0, 1'b0);
        rdchk(12'h010, 32'h30, 32'h20);
        i_line.token(8'h05, 1'b0, 1'b0, 1'b0);
        rdchk(12'h010, 32'h10, 32'h10);
        apb(1'b1, 12'h00C, 8'h33);
        i_line.token(8'h33, 1'b0, 1'b0, 1'b1);
        i_line.next_node(8'h07);
        apb(1'b1, 12'h000, 8'h38);
        @(posedge CLK);
        chk(32'(JOIN_ENABLE), 32'h1);
        i_line.ev(1'b0, 1'b1, 1'b0);
        rdchk(12'h010, 32'h86, 32'h86);
        rdchk(12'h010, 32'hC6, 32'h0);
        // A second self-reconfiguration: the host takes the transmitter off the line
        i_line.ev(1'b0, 1'b1, 1'b0);
        rdchk(12'h010, 32'h80, 32'h80);
        apb(1'b1, 12'h018, 8'h01);
        @(posedge CLK);
        chk(32'(TRANSMIT_ENABLE), 32'h0);
        $display("done diag");
    endtask : t_diag
    task automatic t_nak();
        for (int k = 0; k < 2; k++) begin
            for (int i = 1; i <= 4; i++) begin
                i_line.ev(1'b1, 1'b0, 1'b0);
                rdchk(12'h010, 32'h8, (i == 4) ? 32'h8 : 32'h0);
            end
            apb(1'b1, 12'h018, 8'h1E);
        end
        repeat (4) i_line.ev(1'b1, 1'b0, 1'b0);
        apb(1'b1, 12'h018, 8'h01);
        rdchk(12'h014, 32'h1, 32'h0);
        i_line.token(8'h2A, 1'b0, 1'b1, 1'b0);
        rdchk(12'h014, 32'h1, 32'h1);
        $display("done nak");
    endtask : t_nak
    task automatic t_resets();
        apb(1'b1, 12'h01C, 8'h5A);
        apb(1'b1, 12'h000, 8'hB8);
        repeat (3) @(posedge CLK);
        chk(32'({NODE_IN_RESET, TRANSMIT_ENABLE, CORE_AWAKE}), 32'h4);
        rdchk(12'h000, 32'hFF, 32'hB8);
        rdchk(12'h004, 32'hFF, 32'h01);
        rdchk(12'h028, 32'h2, 32'h2);
        rdchk(12'h01C, 32'hFF, 32'h5A);
        rdchk(12'h008, 32'hFF, 32'h00);
        chk(32'(NODE_IN_RESET), 32'h1);
        apb(1'b1, 12'h000, 8'h18);
        repeat (3) @(posedge CLK);
        chk(32'({NODE_IN_RESET, CORE_AWAKE}), 32'h0);
        RESET_INPUT_LOW <= 1'b0;
        repeat (4) @(posedge CLK);
        RESET_INPUT_LOW <= 1'b1;
        repeat (10) @(posedge CLK);
        rdchk(12'h004, 32'hFF, 32'h01);
        RESET_INPUT_LOW <= 1'b0;
        repeat (12) @(posedge CLK);
        chk(32'(NODE_IN_RESET), 32'h1);
        RESET_INPUT_LOW <= 1'b1;
        repeat (10) @(posedge CLK);
        rdchk(12'h028, 32'h2, 32'h0);
        rdchk(12'h004, 32'hFF, 32'h00);
        rdchk(12'h01C, 32'hFF, 32'h00);
        $display("done resets");
    endtask : t_resets
    initial begin
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK);
        t_wake();
        t_diag();
        t_nak();
        t_resets();
        close_out();
    end
endmodule : tb
